//--- hdl/dfsf_top.sv
/*
 Status flag engine for two clocked FIFOs: the first written on port A and read on
 port B, the second written on port C and read on port A, with an APB register file.
 Assumes the three port clocks and all port requests are asynchronous pins that the
 block samples with pclk; port clocks run well below pclk (about 200 ns periods).
*/
`timescale 1ns/1ps
`default_nettype none
module dfsf_top
   import dfsf_pkg::*;
#(
   parameter int DEPTH_LOG2 = DEPTH_LOG2_DEF
) (
   input wire logic pclk, // APB and sampling clock
   input wire logic presetn, // asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic port_a_clock, // port A clock pin
   input wire logic port_b_clock, // port B clock pin
   input wire logic port_c_clock, // port C clock pin
   input wire logic porta_write_req, // port A write to first FIFO
   input wire logic porta_read_req, // port A read from second FIFO
   input wire logic portb_read_req, // port B read from first FIFO
   input wire logic portc_write_req, // port C write to second FIFO
   output logic porta_empty_or_ready, // second FIFO empty or output ready
   output logic portb_empty_or_ready, // first FIFO empty or output ready
   output logic porta_full_or_input_ready, // first FIFO full or input ready
   output logic portc_full_or_input_ready, // second FIFO full or input ready
   output logic fifo1_near_empty_flag, // first FIFO near empty, port B domain
   output logic fifo2_near_empty_flag, // second FIFO near empty, port A domain
   output logic fifo1_near_full_flag, // first FIFO near full, port A domain
   output logic fifo2_near_full_flag, // second FIFO near full, port C domain
   output logic fifo1_out_load, // pulse: word moved to port B output register
   output logic fifo2_out_load // pulse: word moved to port A output register
);

   localparam dfsf_ptr_t PTR_MASK = dfsf_ptr_t'((18'h0_0001 << (DEPTH_LOG2 + 1)) - 18'h0_0001);
   localparam dfsf_ptr_t DEPTH = dfsf_ptr_t'(18'h0_0001 << DEPTH_LOG2);

   dfsf_state_t s;
   dfsf_state_t next_s;
   logic [1:0] wr_edge;
   logic [1:0] rd_edge;
   logic [1:0] wr_req;
   logic [1:0] rd_req;
   logic [2:0] ck_edge;
   logic apb_wr;
   logic apb_setup;

   // Pointers wrap at twice the depth so empty and full stay distinct. [R22]
   function automatic dfsf_ptr_t ptr_inc(input dfsf_ptr_t p);
      ptr_inc = (p + dfsf_ptr_t'(1)) & PTR_MASK; // [R22]
   endfunction

   function automatic dfsf_ptr_t ptr_diff(input dfsf_ptr_t a, input dfsf_ptr_t b);
      ptr_diff = (a - b) & PTR_MASK;
   endfunction

   function automatic dfsf_ptr_t ofs_ext(input logic [15:0] v);
      ofs_ext = dfsf_ptr_t'(v);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_CTRL) || (a == OFS_LIMITS1) || (a == OFS_LIMITS2) ||
               (a == OFS_FLAGS) || (a == OFS_FILL1) || (a == OFS_FILL2);
   endfunction

   // Edges of the port clocks, found after two sampling stages; stage one feeds only stage two.
   assign ck_edge = s.pins.ck2 & ~s.pins.ck3; // [R1]
   // First FIFO: written on port A, read on port B; second: written on C, read on A. [R2]
   assign wr_edge = {ck_edge[2], ck_edge[0]}; // [R2]
   assign rd_edge = {ck_edge[0], ck_edge[1]}; // [R2]
   assign wr_req = {s.pins.rq2[3], s.pins.rq2[0]};
   assign rd_req = {s.pins.rq2[1], s.pins.rq2[2]};

   assign apb_wr = psel && penable && pwrite;
   assign apb_setup = psel && !penable;

   always_comb begin
      next_s = s;
      next_s.pins.ck1 = {port_c_clock, port_b_clock, port_a_clock};
      next_s.pins.ck2 = s.pins.ck1;
      next_s.pins.ck3 = s.pins.ck2;
      next_s.pins.rq1 = {portc_write_req, portb_read_req, porta_read_req, porta_write_req};
      next_s.pins.rq2 = s.pins.rq1;

      for (int i = 0; i < 2; i++) begin
         next_s.f[i].oload = 1'b0;
         // Pointer ageing lines model the skew limit: a pointer becomes visible to the
         // other port only once it is old enough, else the following edge takes it.
         next_s.f[i].wdl[0] = s.f[i].wptr; // [R15]
         next_s.f[i].rdl[0] = s.f[i].rptr; // [R19]
         for (int k = 1; k < DL_LEN; k++) begin
            next_s.f[i].wdl[k] = s.f[i].wdl[k-1];
            next_s.f[i].rdl[k] = s.f[i].rdl[k-1];
         end

         // Read side, on the reading port clock.
         if (rd_edge[i]) begin
            next_s.f[i].ws1 = s.f[i].wdl[EF_SKEW_CYC-1]; // [R15] [R1]
            next_s.f[i].ws2 = s.f[i].ws1; // [R1]
            next_s.f[i].wa1 = s.f[i].wdl[AF_SKEW_CYC-1]; // [R15]
            if (s.fall_through_mode) begin
               // Output-ready state machine: third edge loads the word and raises ready.
               if (!s.f[i].ef || rd_req[i]) begin // [R10]
                  // The second stage holds the pointer taken two edges ago, so this is edge three.
                  if (ptr_diff(s.f[i].ws2, s.f[i].rptr) != '0) begin // [R13]
                     next_s.f[i].rptr = ptr_inc(s.f[i].rptr); // [R12] [R8]
                     next_s.f[i].ef = 1'b1; // [R13] [R9]
                     next_s.f[i].oload = 1'b1; // [R8]
                  end else begin
                     next_s.f[i].ef = 1'b0; // [R10]
                  end
               end
            end else begin
               // Reads while empty is low are discarded. [R11]
               if (s.f[i].ef && rd_req[i]) begin // [R11]
                  next_s.f[i].rptr = ptr_inc(s.f[i].rptr); // [R12]
                  next_s.f[i].oload = 1'b1;
               end
               // Empty goes high on the second edge after the write. [R14]
               next_s.f[i].ef = (ptr_diff(s.f[i].ws1, next_s.f[i].rptr) != '0); // [R14] [R9]
            end
            // Memory count excludes the output register word. [R7]
            next_s.f[i].ae = (ptr_diff(s.f[i].wa1, next_s.f[i].rptr) >
                              ofs_ext(s.ne_ofs[i])); // [R3] [R5] [R20] [R7]
         end

         // Write side, on the writing port clock.
         if (wr_edge[i]) begin
            next_s.f[i].rs1 = s.f[i].rdl[EF_SKEW_CYC-1]; // [R19] [R1]
            next_s.f[i].ra1 = s.f[i].rdl[AF_SKEW_CYC-1]; // [R19]
            if (s.f[i].ff && wr_req[i]) begin // [R16]
               next_s.f[i].wptr = ptr_inc(s.f[i].wptr); // [R17]
            end
            // Flag reflects the pointer seen after two edges of the writing clock.
            next_s.f[i].ff = (ptr_diff(next_s.f[i].wptr, s.f[i].rs1) != DEPTH); // [R16] [R18]
            next_s.f[i].af = (ptr_diff(next_s.f[i].wptr, s.f[i].ra1) <
                              (DEPTH - ofs_ext(s.nf_ofs[i]))); // [R4] [R6] [R21]
         end
      end

      if (apb_wr) begin
         case (paddr)
            OFS_CTRL: begin
               next_s.fall_through_mode = pwdata[CTRL_FALL_THROUGH_MODE_BIT]; // [R9]
            end
            OFS_LIMITS1: begin
               next_s.ne_ofs[0] = pwdata[LIM_NE_LSB +: 16];
               next_s.nf_ofs[0] = pwdata[LIM_NF_LSB +: 16];
            end
            OFS_LIMITS2: begin
               next_s.ne_ofs[1] = pwdata[LIM_NE_LSB +: 16];
               next_s.nf_ofs[1] = pwdata[LIM_NF_LSB +: 16];
            end
            default: begin
            end
         endcase
      end

      // Read data is fetched in the setup phase so it stands registered in the access phase.
      if (apb_setup && !pwrite) begin
         next_s.prdata = 32'h0000_0000;
         case (paddr)
            OFS_CTRL: begin
               next_s.prdata[CTRL_FALL_THROUGH_MODE_BIT] = s.fall_through_mode;
            end
            OFS_LIMITS1: begin
               next_s.prdata = {s.nf_ofs[0], s.ne_ofs[0]};
            end
            OFS_LIMITS2: begin
               next_s.prdata = {s.nf_ofs[1], s.ne_ofs[1]};
            end
            OFS_FLAGS: begin
               next_s.prdata[3:0] = {s.f[0].ff, s.f[0].af, s.f[0].ae, s.f[0].ef};
               next_s.prdata[FLAGS_FIFO2_LSB +: 4] = {s.f[1].ff, s.f[1].af, s.f[1].ae,
                                                      s.f[1].ef};
            end
            OFS_FILL1: begin
               next_s.prdata[PTR_W-1:0] = ptr_diff(s.f[0].wptr, s.f[0].rptr);
            end
            OFS_FILL2: begin
               next_s.prdata[PTR_W-1:0] = ptr_diff(s.f[1].wptr, s.f[1].rptr);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         // Clock pin samples start high so a port clock already high at release is no edge.
         s.pins.ck1 <= 3'h7;
         s.pins.ck2 <= 3'h7;
         s.pins.ck3 <= 3'h7;
         s.fall_through_mode <= RST_FALL_THROUGH_MODE;
         s.ne_ofs <= {RST_NEAR_EMPTY_OFS, RST_NEAR_EMPTY_OFS};
         s.nf_ofs <= {RST_NEAR_FULL_OFS, RST_NEAR_FULL_OFS};
         s.f[0].af <= 1'b1;
         s.f[0].ff <= 1'b1;
         s.f[1].af <= 1'b1;
         s.f[1].ff <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign prdata = s.prdata;

   assign portb_empty_or_ready = s.f[0].ef; // [R2]
   assign fifo1_near_empty_flag = s.f[0].ae;
   assign porta_full_or_input_ready = s.f[0].ff;
   assign fifo1_near_full_flag = s.f[0].af;
   assign porta_empty_or_ready = s.f[1].ef;
   assign fifo2_near_empty_flag = s.f[1].ae;
   assign portc_full_or_input_ready = s.f[1].ff;
   assign fifo2_near_full_flag = s.f[1].af;
   assign fifo1_out_load = s.f[0].oload;
   assign fifo2_out_load = s.f[1].oload;

endmodule // dfsf_top
`default_nettype wire

//--- hdl/dfsf_pkg.sv
/*
 Constants, field layouts and state types for the dual FIFO status flag block.
 Assumes one system clock (pclk, 40 MHz) and an APB master reaching the registers.
*/
// Summary of operation
// R1: Two-stage synchronise every flag into owning port.
// R2: Port A, B and C each own their flags.
// R3: First FIFO near-empty low up to its offset.
// R4: First FIFO near-full low at depth minus offset.
// R5: Second FIFO near-empty uses its own offset.
// R6: Second FIFO near-full uses its own offset.
// R7: Output register word is not counted.
// R8: Fall-through loads first word without a read.
// R9: Mode selects empty/full or ready meaning.
// R10: Output-ready low holds word, ignores reads.
// R11: Empty low holds word, ignores reads.
// R12: Read pointer advances per output register load.
// R13: Fall-through ready and load on third edge.
// R14: Standard empty flag rises on second edge.
// R15: Write-to-read skew decides first sync edge.
// R16: Full/input-ready low only when full; writes ignored.
// R17: Write pointer advances per accepted write.
// R18: Freed location shows on second write edge.
// R19: Read-to-write skew decides first sync edge.
// R20: Near-empty updates two read edges after write.
// R21: Near-full updates two write edges after read.
// R22: Depth parameterised, pointers one bit wider.
package dfsf_pkg;
   localparam int PTR_W = 17;
   localparam int DEPTH_LOG2_DEF = 14;
   localparam int CLK_PERIOD_NS = 25;
   localparam int EMPTY_FULL_SKEW_LIMIT_NS = 5;
   localparam int ALMOST_FLAG_SKEW_LIMIT_NS = 5;
   localparam int EF_SKEW_CYC_RAW = (EMPTY_FULL_SKEW_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AF_SKEW_CYC_RAW = (ALMOST_FLAG_SKEW_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EF_SKEW_CYC = (EF_SKEW_CYC_RAW < 1) ? 1 : EF_SKEW_CYC_RAW;
   localparam int AF_SKEW_CYC = (AF_SKEW_CYC_RAW < 1) ? 1 : AF_SKEW_CYC_RAW;
   localparam int DL_LEN = (EF_SKEW_CYC > AF_SKEW_CYC) ? EF_SKEW_CYC : AF_SKEW_CYC;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LIMITS1 = 8'h04;
   localparam logic [7:0] OFS_LIMITS2 = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_FILL1 = 8'h10;
   localparam logic [7:0] OFS_FILL2 = 8'h14;

   localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
   localparam int LIM_NE_LSB = 0;
   localparam int LIM_NF_LSB = 16;
   localparam int FLAGS_FIFO2_LSB = 4;

   localparam logic RST_FALL_THROUGH_MODE = 1'b0;
   localparam logic [15:0] RST_NEAR_EMPTY_OFS = 16'h0008;
   localparam logic [15:0] RST_NEAR_FULL_OFS = 16'h0008;

   typedef logic [PTR_W-1:0] dfsf_ptr_t;

   typedef struct packed {
      logic [2:0] ck1;
      logic [2:0] ck2;
      logic [2:0] ck3;
      logic [3:0] rq1;
      logic [3:0] rq2;
   } dfsf_pins_t;

   typedef struct packed {
      dfsf_ptr_t wptr;
      dfsf_ptr_t rptr;
      dfsf_ptr_t [DL_LEN-1:0] wdl;
      dfsf_ptr_t ws1;
      dfsf_ptr_t ws2;
      dfsf_ptr_t wa1;
      dfsf_ptr_t [DL_LEN-1:0] rdl;
      dfsf_ptr_t rs1;
      dfsf_ptr_t ra1;
      logic ef;
      logic ae;
      logic af;
      logic ff;
      logic oload;
   } dfsf_fifo_t;

   typedef struct packed {
      dfsf_pins_t pins;
      dfsf_fifo_t [1:0] f;
      logic fall_through_mode;
      logic [1:0][15:0] ne_ofs;
      logic [1:0][15:0] nf_ofs;
      logic [31:0] prdata;
   } dfsf_state_t;
endpackage : dfsf_pkg

//--- verif/dfsf_chk_asserts.sv
/* Pin-level assertions for dfsf_top.
 Assumes a bind into dfsf_top and port clocks far slower than pclk. */
`timescale 1ns/1ps
`default_nettype none
module dfsf_chk (
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic port_a_clock, // pin
   input wire logic port_b_clock, // pin
   input wire logic port_c_clock, // pin
   input wire logic porta_read_req, // pin
   input wire logic portb_read_req, // pin
   input wire logic porta_empty_or_ready, // flag
   input wire logic portb_empty_or_ready, // flag
   input wire logic porta_full_or_input_ready, // flag
   input wire logic portc_full_or_input_ready, // flag
   input wire logic fifo1_near_empty_flag, // flag
   input wire logic fifo2_near_empty_flag, // flag
   input wire logic fifo1_near_full_flag, // flag
   input wire logic fifo2_near_full_flag, // flag
   input wire logic fifo1_out_load, // pulse
   input wire logic fifo2_out_load // pulse
);
   logic [2:0][3:0] age;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since each port clock pin rose; a flag owned by that port moves only shortly after.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age <= '1;
      end else begin
         age[0] <= $rose(port_a_clock) ? 4'h0 : age[0] + {3'h0, age[0] != 4'hF};
         age[1] <= $rose(port_b_clock) ? 4'h0 : age[1] + {3'h0, age[1] != 4'hF};
         age[2] <= $rose(port_c_clock) ? 4'h0 : age[2] + {3'h0, age[2] != 4'hF};
      end
   end
   a_port_a_domain: assert property ($changed({porta_empty_or_ready, fifo2_near_empty_flag,
      porta_full_or_input_ready, fifo1_near_full_flag}) |-> age[0] inside {[2:7]})
      else $error("port A flag moved off its clock");
   a_port_b_domain: assert property ($changed({portb_empty_or_ready,
      fifo1_near_empty_flag, fifo1_out_load}) |-> age[1] inside {[2:7]})
      else $error("port B flag moved off its clock");
   a_port_c_domain: assert property ($changed({portc_full_or_input_ready,
      fifo2_near_full_flag}) |-> age[2] inside {[2:7]}) else $error("port C flag off clock");
   a_load_one_cycle: assert property (fifo1_out_load |=> !fifo1_out_load)
      else $error("load pulse too long");
   a_b_read_gate: assert property (fifo1_out_load && $past(portb_empty_or_ready)
      |-> $past(portb_read_req, 3)) else $error("port B load without read");
   a_a_read_gate: assert property (fifo2_out_load && $past(porta_empty_or_ready)
      |-> $past(porta_read_req, 3)) else $error("port A load without read");
   a_b_auto_load: assert property (fifo1_out_load && !$past(portb_empty_or_ready)
      |-> portb_empty_or_ready) else $error("port B load while not ready");
   a_a_auto_load: assert property (fifo2_out_load && !$past(porta_empty_or_ready)
      |-> porta_empty_or_ready) else $error("port A load while not ready");
   c_b_load: cover property (fifo1_out_load);
   c_a_full: cover property (!porta_full_or_input_ready);
   c_a_auto: cover property (fifo2_out_load && !$past(porta_empty_or_ready));
endmodule // dfsf_chk
`default_nettype wire

//--- verif/dfsf_hosts.sv
/* Hosts on ports A, B and C: free-running port clocks and request pins.
 Assumes the bench sets want bits at pclk edges and watches done counts. */
`timescale 1ns/1ps
`default_nettype none
module dfsf_hosts (
   input wire logic pclk, // sampling clock
   input wire logic [3:0] want, // A write, A read, B read, C write
   output logic [2:0] clk, // port A, B, C clocks
   output logic [3:0] req, // request pins
   output logic [3:0][7:0] done // rises seen with a request
);
   logic [2:0] seen;
   initial begin
      clk = 3'h2;
      seen = 3'h2;
      req = 4'h0;
      done = '0;
   end
   always #100 clk[1:0] = ~clk[1:0];
   initial begin
      #50;
      forever #100 clk[2] = ~clk[2];
   end
   // Requests move only after a fall, so they sit still around every rise.
   always @(posedge pclk) begin
      int k;
      seen <= clk;
      for (int i = 0; i < 4; i++) begin
         k = (i < 2) ? 0 : i - 1;
         if (seen[k] && !clk[k]) begin
            req[i] <= want[i];
         end
         if (!seen[k] && clk[k] && req[i]) begin
            done[i] <= done[i] + 8'h01;
         end
      end
   end
endmodule // dfsf_hosts
`default_nettype wire

//--- verif/tb.sv
/* Bench for dfsf_top: APB register tasks and host-driven port transfers.
 Assumes depth 16 and offsets 2, so that every flag threshold is crossed. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, ex;
   logic [3:0] want, req;
   logic [2:0] clk;
   logic [3:0][7:0] done;
   wire [7:0] pin_flags;
   int failures, num_checks, cyc, n;
   dfsf_top #(.DEPTH_LOG2(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_a_clock(clk[0]), .port_b_clock(clk[1]),
      .port_c_clock(clk[2]), .porta_write_req(req[0]), .porta_read_req(req[1]),
      .portb_read_req(req[2]), .portc_write_req(req[3]), .porta_empty_or_ready(pin_flags[4]),
      .portb_empty_or_ready(pin_flags[0]), .porta_full_or_input_ready(pin_flags[3]),
      .portc_full_or_input_ready(pin_flags[7]), .fifo1_near_empty_flag(pin_flags[1]),
      .fifo2_near_empty_flag(pin_flags[5]), .fifo1_near_full_flag(pin_flags[2]),
      .fifo2_near_full_flag(pin_flags[6]), .fifo1_out_load(), .fifo2_out_load());
   dfsf_hosts host_u (.pclk(pclk), .want(want), .clk(clk), .req(req), .done(done));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         final_report();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks = num_checks + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("[FAIL] %0t got %h expected %h", $time, s, e);
      end
   endtask
   task automatic xfer(input int i);
      logic [7:0] d0;
      d0 = done[i];
      want[i] <= 1'b1;
      do @(posedge pclk); while (done[i] === d0);
      want[i] <= 1'b0;
      repeat (40) @(posedge pclk); // flags need two or three far-side edges
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, want} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0000_00CC);
      apb(1'b0, 8'h3C, 32'h0);
      chk({q[30:0], err}, 32'h0000_0001);
      // Seventeen writes then seventeen reads, so the last of each is refused.
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, 8'h04 + 8'(4 * f), 32'h0002_0002);
         apb(1'b0, 8'h04 + 8'(4 * f), 32'h0);
         chk(q, 32'h0002_0002);
         for (int s = 0; s < 34; s++) begin
            xfer(s < 17 ? 3 * f : 2 - f);
            n = s < 17 ? n + (n < 16) : n - (n > 0);
            apb(1'b0, 8'h10 + 8'(4 * f), 32'h0);
            chk(q, 32'(n));
            apb(1'b0, 8'h0C, 32'h0);
            ex = {28'h0, n < 16, n < 14, n > 2, n > 0};
            chk((q >> (4 * f)) & 32'h0000_000F, ex);
            chk(32'(pin_flags >> (4 * f)) & 32'h0000_000F, ex);
         end
      end
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0000_0001);
      xfer(0);
      xfer(3);
      apb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0000_00DD);
      chk(32'(pin_flags), 32'h0000_00DD);
      xfer(1);
      apb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0000_00CD);
      chk(32'(pin_flags), 32'h0000_00CD);
      final_report();
   end
endmodule // tb
bind dfsf_top dfsf_chk chk_u (.pclk(pclk), .presetn(presetn), .port_a_clock(port_a_clock),
   .port_b_clock(port_b_clock), .port_c_clock(port_c_clock), .porta_read_req(porta_read_req),
   .portb_read_req(portb_read_req), .porta_empty_or_ready(porta_empty_or_ready),
   .portb_empty_or_ready(portb_empty_or_ready),
   .porta_full_or_input_ready(porta_full_or_input_ready),
   .portc_full_or_input_ready(portc_full_or_input_ready),
   .fifo1_near_empty_flag(fifo1_near_empty_flag), .fifo2_near_empty_flag(fifo2_near_empty_flag),
   .fifo1_near_full_flag(fifo1_near_full_flag), .fifo2_near_full_flag(fifo2_near_full_flag),
   .fifo1_out_load(fifo1_out_load), .fifo2_out_load(fifo2_out_load));
`default_nettype wire
